// >>> testbench/pixel_sink_model.sv
// Far-side model of the pipeline stage that takes mapped pixels
// Assumes the mapper output handshake on clk_sys, ready changed after edges
////////////////////////////////////////////////////////////////////////////////
module pixel_sink_model (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // Pace: 0 prompt, 1 slow, 2 stopped
    input  wire logic [1:0] mode,
    // Mapped pixel handshake
    output logic            pix_out_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase_reg;

    // Slow pace takes one pixel in three, so the output buffer backs up
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            phase_reg     <= 2'h0;
            pix_out_ready <= 1'b0;
        end else begin
            phase_reg     <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
            pix_out_ready <= (mode == 2'h0) || (mode == 2'h1 && phase_reg == 2'h0);
        end
    end
endmodule : pixel_sink_model

// >>> testbench/tb_top.sv
// Self-checking bench for the pixel lookup mapper
// Assumes the design package, the sink model and a 250 MHz clock
////////////////////////////////////////////////////////////////////////////////
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [9:0] v;
        logic [7:0] g;
        logic [7:0] b;
        logic [7:0] e;
    } row_t;
    logic                  clk_sys = 1'b0;
    logic                  rst_n = 1'b0;
    logic [12:0]           s_axi_awaddr = 13'h0000, s_axi_araddr = 13'h0000;
    logic [31:0]           s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
    logic [1:0]            s_axi_bresp, s_axi_rresp, rs, sink_mode = 2'h0;
    logic                  s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic                  s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid;
    logic                  s_axi_rvalid, pix_in_ready, pix_out_valid, pix_out_ready;
    logic                  s_axi_bready = 1'b1, s_axi_rready = 1'b1, saw_full = 1'b0;
    logic                  pix_in_valid = 1'b0;
    logic [3:0]            s_axi_wstrb = 4'hf;
    lut_map_pkg::pix_in_t  pix_in = '0;
    lut_map_pkg::pix_out_t pix_out;
    lut_map_pkg::pix_out_t exp_q[$];
    int                    mismatches = 0, check_count = 0, sent = 0, n = 0;
    int                    keys[5] = '{0, 1, 100, 501, 1023};
    row_t                  rows[6] = '{'{10'h000, 8'h10, 8'h00, 8'h00},
        '{10'h3ff, 8'h10, 8'h00, 8'hff}, '{10'h0c8, 8'h40, 8'h05, 8'hcd},
        '{10'h064, 8'h20, 8'h0a, 8'h3c}, '{10'h0fa, 8'h08, 8'h80, 8'h9f},
        '{10'h001, 8'h10, 8'h00, 8'h00}};

    always #2 clk_sys = ~clk_sys;

    // Design and far-side model
    pixel_lookup_table_mapper dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .pix_in(pix_in), .pix_in_valid(pix_in_valid),
        .pix_in_ready(pix_in_ready), .pix_out(pix_out), .pix_out_valid(pix_out_valid),
        .pix_out_ready(pix_out_ready));
    pixel_sink_model sink_u (.clk_sys(clk_sys), .rst_n(rst_n), .mode(sink_mode),
        .pix_out_ready(pix_out_ready));

    ////////////////////////////////////////////////////////////////////////////
    // Comparison, report and timeout
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    task automatic step();
        @(posedge clk_sys);
        n++;
        if (n > 3000) begin
            check("wait bound", 32'h0, 32'h1);
            final_report();
        end
    endtask : step

    function automatic logic [7:0] conv(input int v, input int g, input int b);
        int t;
        t = ((v * g) >> 6) + b;
        return (t > 255) ? 8'hff : t[7:0];
    endfunction : conv

    ////////////////////////////////////////////////////////////////////////////
    // Register bus master
    task automatic axi_write(input logic [12:0] a, input logic [31:0] d);
        n = 0;
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wvalid  <= 1'b1;
        repeat (3001) begin
            step();
            if (s_axi_bvalid) begin
                rs = s_axi_bresp;
                break;
            end
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end
    endtask : axi_write

    task automatic axi_read(input logic [12:0] a);
        n = 0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        repeat (3001) begin
            step();
            if (s_axi_rvalid) begin
                rd = s_axi_rdata;
                rs = s_axi_rresp;
                break;
            end
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end
    endtask : axi_read

    ////////////////////////////////////////////////////////////////////////////
    // Pixel source, drain wait and output monitor
    task automatic send_pix(input logic [9:0] v, input logic s, input logic l,
                            input logic [7:0] e);
        n = 0;
        pix_in       <= '{v, s, l};
        pix_in_valid <= 1'b1;
        do step(); while (!pix_in_ready);
        exp_q.push_back('{e, s, l});
        sent++;
    endtask : send_pix

    task automatic drain();
        n = 0;
        pix_in_valid <= 1'b0;
        while (exp_q.size() != 0) step();
    endtask : drain

    // Every pixel leaving must be the next expected one, framing included
    always @(posedge clk_sys) begin
        if (rst_n && pix_out_valid && pix_out_ready) begin
            if (exp_q.size() == 0) check("extra pixel", 32'h0, 32'h1);
            else check("pixel", 32'(exp_q.pop_front()), 32'(pix_out));
        end
        if (pix_in_valid && !pix_in_ready) saw_full <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        foreach (rows[i]) begin
            axi_write(lut_map_pkg::gain_off, {24'h0, rows[i].g});
            axi_write(lut_map_pkg::bright_off, {24'h0, rows[i].b});
            send_pix(rows[i].v, 1'b1, 1'b1, rows[i].e);
            drain();
        end
        $display("test conversion done");
        axi_write(lut_map_pkg::gain_off, 32'h20);
        axi_write(lut_map_pkg::bright_off, 32'h05);
        axi_write(lut_map_pkg::ctrl_off, 32'h8000_0000);
        check("enable resp", 32'(lut_map_pkg::resp_okay), 32'(rs));
        // Host waits for the auto-fill before loading its own entries
        for (int k = 0; k < 2000; k++) begin
            axi_read(lut_map_pkg::status_off);
            if (rd[0] === 1'b0) break;
        end
        check("fill done", 32'h0, {31'h0, rd[0]});
        foreach (keys[i]) begin
            axi_read(lut_map_pkg::table_base + 13'(4 * keys[i]));
            check("filled entry", {24'h0, conv(keys[i], 32, 5)}, rd);
        end
        axi_read(lut_map_pkg::ctrl_off);
        check("ctrl on", 32'h8000_0001, rd);
        axi_write(lut_map_pkg::gain_off, 32'h40);
        send_pix(10'd100, 1'b1, 1'b1, conv(100, 32, 5));
        drain();
        $display("test fill done");
        axi_write(lut_map_pkg::table_base, 32'habcd_ef5a);
        axi_write(lut_map_pkg::table_base + 13'h0800, 32'h3c);
        axi_write(lut_map_pkg::table_last, 32'ha5);
        axi_read(lut_map_pkg::table_base);
        check("entry upper zero", 32'h5a, rd);
        send_pix(10'd0, 1'b1, 1'b0, 8'h5a);
        send_pix(10'd512, 1'b0, 1'b0, 8'h3c);
        send_pix(10'd1023, 1'b0, 1'b1, 8'ha5);
        drain();
        axi_write(lut_map_pkg::depth_off, 32'h0);
        axi_read(lut_map_pkg::depth_off);
        check("depth ro", lut_map_pkg::depth_value, rd);
        axi_write(lut_map_pkg::ctrl_off, 32'h0);
        axi_read(lut_map_pkg::ctrl_off);
        check("ctrl off", 32'h1, rd);
        s_axi_wstrb <= 4'h7;
        axi_write(lut_map_pkg::ctrl_off, 32'h8000_0000);
        s_axi_wstrb <= 4'hf;
        axi_read(lut_map_pkg::ctrl_off);
        check("ctrl strobe", 32'h1, rd);
        $display("test table done");
        sent = 0;
        sink_mode <= 2'h2;
        fork
            begin
                for (int i = 0; i < 20; i++) begin
                    send_pix(10'(i * 40), i == 0, i == 19, conv(i * 40, 64, 5));
                end
            end
            begin
                repeat (40) @(posedge clk_sys);
                check("stall refused", 32'h1, {31'h0, sent < 20});
                sink_mode <= 2'h1;
            end
        join
        drain();
        check("fifo full seen", 32'h1, {31'h0, saw_full});
        sink_mode <= 2'h0;
        $display("test burst done");
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        axi_read(lut_map_pkg::ctrl_off);
        check("ctrl reset", 32'h1, rd);
        axi_read(lut_map_pkg::gain_off);
        check("gain reset", {24'h0, lut_map_pkg::gain_reset}, rd);
        axi_read(13'h1014);
        check("unmapped resp", 32'(lut_map_pkg::resp_slverr), 32'(rs));
        $display("test reset done");
        final_report();
    end
endmodule : tb_top

// >>> verilog/lut_map_pkg.sv
// Constants and carrier types for the pixel lookup mapper
// Assumes one 250 MHz clock and a synchronous active-low reset
// Overview of operation
// R01 - Table off: gain and brightness convert pixels
// R02 - Table on: output comes only from table
// R03 - 1024 entries, index equals sensor value
// R04 - Two control quadlets, then 1024 entry quadlets
// R05 - Presence indication readable in control quadlet
// R06 - Enabling auto-fills table from gain, brightness
// R07 - Host enables first, then writes entries
// R08 - No data inserted into the pixel stream
// R09 - Works for every video format setting
// R10 - Presence is read-only bit 0, reads 1
// R11 - Enable is read/write bit 31
// R12 - Entry value in low 8 bits, rest zero
// R13 - One pixel per clock, fixed latency, framing kept
package lut_map_pkg;
    localparam logic [12:0] ctrl_off     = 13'h0000;
    localparam logic [12:0] depth_off    = 13'h0004;
    localparam logic [12:0] table_base   = 13'h0008;
    localparam logic [12:0] table_last   = 13'h1004;
    localparam logic [12:0] gain_off     = 13'h1008;
    localparam logic [12:0] bright_off   = 13'h100c;
    localparam logic [12:0] status_off   = 13'h1010;
    localparam int          presence_bit = 0;
    localparam int          enable_bit   = 31;
    localparam logic [31:0] depth_value  = 32'h0008_000a;
    localparam logic [7:0]  gain_reset   = 8'h10;
    localparam logic [7:0]  bright_reset = 8'h00;
    localparam logic [1:0]  resp_okay    = 2'h0;
    localparam logic [1:0]  resp_slverr  = 2'h2;
    localparam int          fill_words   = 1024;

    // Pixel with its framing marks
    typedef struct packed {
        logic [9:0] value;
        logic       sof;
        logic       eol;
    } pix_in_t;

    typedef struct packed {
        logic [7:0] value;
        logic       sof;
        logic       eol;
    } pix_out_t;
endpackage : lut_map_pkg

// >>> verilog/pixel_lookup_table_mapper.sv
// Pixel lookup mapper with AXI4-Lite registers and an output FIFO
// Assumes a downstream sink with ready and a host on AXI4-Lite
////////////////////////////////////////////////////////////////////////////////
module lut_fifo #(
    parameter int width = 10,
    parameter int depth = 8
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [width-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [width-1:0] out_data
);
    localparam int aw = $clog2(depth);
    if (depth < 2 || (1 << aw) != depth) begin : g_depth_chk
        $error("depth must be a power of two");
    end
    logic [width-1:0] mem [depth];
    logic [aw:0]      wr_reg;
    logic [aw:0]      rd_reg;
    logic             push;
    logic             pop;

    // Honest full and empty from pointer distance
    assign in_ready  = (wr_reg - rd_reg) != (aw + 1)'(depth);
    assign out_valid = wr_reg != rd_reg;
    assign out_data  = mem[rd_reg[aw-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage write
    always_ff @(posedge clk_sys) begin
        if (push) mem[wr_reg[aw-1:0]] <= in_data;
    end

    // Pointers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            if (push) wr_reg <= wr_reg + 1'b1;
            if (pop) rd_reg <= rd_reg + 1'b1;
        end
    end

    fifo_bound_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wr_reg - rd_reg) <= (aw + 1)'(depth)) else $error("fifo overfilled"); // [R13]
endmodule : lut_fifo

////////////////////////////////////////////////////////////////////////////////
module pixel_lookup_table_mapper #(
    parameter int fifo_depth = 8
) (
    // Clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    // AXI4-Lite write
    input  wire logic [12:0]            s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // AXI4-Lite read
    input  wire logic [12:0]            s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // Sensor pixel stream
    input  wire lut_map_pkg::pix_in_t   pix_in,
    input  wire logic                   pix_in_valid,
    output logic                        pix_in_ready,
    // Mapped pixel stream
    output lut_map_pkg::pix_out_t       pix_out,
    output logic                        pix_out_valid,
    input  wire logic                   pix_out_ready
);
    typedef enum logic [1:0] {st_idle = 2'b00, st_fill = 2'b01} fill_t;

    // Default conversion: drop two bits, apply gain (x/16) and offset, saturate
    function automatic logic [7:0] convert(input logic [9:0] v, input logic [7:0] g,
                                           input logic [7:0] b);
        logic [19:0] p;
        logic [12:0] s;
        p = 20'(v) * 20'(g);
        s = 13'(p[19:6]) + 13'(b);
        return (s > 13'h00ff) ? 8'hff : s[7:0];
    endfunction : convert

    function automatic logic map_hit(input logic [12:0] a);
        return a >= lut_map_pkg::table_base && a <= lut_map_pkg::table_last;
    endfunction : map_hit

    function automatic logic [9:0] map_index(input logic [12:0] a);
        logic [12:0] d;
        d = a - lut_map_pkg::table_base;
        return d[11:2];
    endfunction : map_index

    logic [7:0]  table_mem [1024];
    logic        enable_reg;
    logic [7:0]  gain_reg;
    logic [7:0]  bright_reg;
    logic [7:0]  fill_gain_reg;
    logic [7:0]  fill_bright_reg;
    fill_t       fill_reg;
    logic [9:0]  fill_idx_reg;
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [12:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        do_write;
    logic        en_rise;
    logic [31:0] rd_next;
    logic        rd_pend_reg;
    logic [12:0] araddr_reg;
    logic        stage_valid_reg;
    lut_map_pkg::pix_in_t stage_reg;
    logic [7:0]  lut_word_reg;
    logic [7:0]  conv_reg;
    logic        use_tab_reg;
    logic        stage2_valid_reg;
    lut_map_pkg::pix_in_t stage2_reg;
    logic        fifo_ready;
    logic        adv;
    lut_map_pkg::pix_out_t fifo_out;
    logic        fifo_out_valid;

    if (fifo_depth < 4) begin : g_fifo_depth_chk
        $error("fifo_depth too small for the pipeline skid");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign en_rise       = do_write && awaddr_reg == lut_map_pkg::ctrl_off && wstrb_reg[3]
                           && wdata_reg[lut_map_pkg::enable_bit] && !enable_reg;

    // Capture address and data, answer when both are held
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            awaddr_reg   <= '0;
            wdata_reg    <= '0;
            wstrb_reg    <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= lut_map_pkg::resp_okay;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (map_hit(awaddr_reg) || awaddr_reg <= lut_map_pkg::status_off)
                                && awaddr_reg[1:0] == 2'b00
                                ? lut_map_pkg::resp_okay : lut_map_pkg::resp_slverr;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Control registers: enable, gain, brightness
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            enable_reg <= 1'b0;
            gain_reg   <= lut_map_pkg::gain_reset;
            bright_reg <= lut_map_pkg::bright_reset;
        end else if (do_write) begin
            if (awaddr_reg == lut_map_pkg::ctrl_off && wstrb_reg[3])
                enable_reg <= wdata_reg[lut_map_pkg::enable_bit]; // [R11]
            if (awaddr_reg == lut_map_pkg::gain_off && wstrb_reg[0])
                gain_reg <= wdata_reg[7:0];
            if (awaddr_reg == lut_map_pkg::bright_off && wstrb_reg[0])
                bright_reg <= wdata_reg[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Auto-fill walker, settings frozen at the enabling write
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fill_reg        <= st_idle;
            fill_idx_reg    <= '0;
            fill_gain_reg   <= lut_map_pkg::gain_reset;
            fill_bright_reg <= lut_map_pkg::bright_reset;
        end else begin
            case (fill_reg)
                st_idle: begin
                    if (en_rise) begin // [R06]
                        fill_reg        <= st_fill;
                        fill_idx_reg    <= '0;
                        fill_gain_reg   <= gain_reg;
                        fill_bright_reg <= bright_reg;
                    end
                end
                st_fill: begin
                    fill_idx_reg <= fill_idx_reg + 1'b1;
                    if (fill_idx_reg == 10'(lut_map_pkg::fill_words - 1)) fill_reg <= st_idle;
                end
                default: fill_reg <= st_idle;
            endcase
        end
    end

    // Table port: fill has the port; host writes to entries during fill are dropped
    always_ff @(posedge clk_sys) begin
        if (fill_reg == st_fill)
            table_mem[fill_idx_reg] <= convert(fill_idx_reg, fill_gain_reg, fill_bright_reg);
        else if (do_write && map_hit(awaddr_reg) && wstrb_reg[0])
            table_mem[map_index(awaddr_reg)] <= wdata_reg[7:0]; // [R03] [R12]
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data decode
    always_comb begin
        rd_next = 32'h0000_0000;
        if (araddr_reg == lut_map_pkg::ctrl_off) begin
            rd_next[lut_map_pkg::presence_bit] = 1'b1; // [R05] [R10]
            rd_next[lut_map_pkg::enable_bit]   = enable_reg;
        end else if (araddr_reg == lut_map_pkg::depth_off) begin
            rd_next = lut_map_pkg::depth_value;
        end else if (map_hit(araddr_reg)) begin
            rd_next = {24'h000000, table_mem[map_index(araddr_reg)]}; // [R04] [R12]
        end else if (araddr_reg == lut_map_pkg::gain_off) begin
            rd_next = {24'h000000, gain_reg};
        end else if (araddr_reg == lut_map_pkg::bright_off) begin
            rd_next = {24'h000000, bright_reg};
        end else if (araddr_reg == lut_map_pkg::status_off) begin
            rd_next = {31'h00000000, fill_reg == st_fill};
        end
    end

    assign s_axi_arready = !rd_pend_reg && !s_axi_rvalid;

    // Read channel: address taken, data answered next cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_pend_reg  <= 1'b0;
            araddr_reg   <= '0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= lut_map_pkg::resp_okay;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                rd_pend_reg <= 1'b1;
                araddr_reg  <= s_axi_araddr;
            end
            if (rd_pend_reg) begin
                rd_pend_reg  <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_next;
                s_axi_rresp  <= (araddr_reg <= lut_map_pkg::status_off && araddr_reg[1:0] == 2'b00)
                                ? lut_map_pkg::resp_okay : lut_map_pkg::resp_slverr;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pixel pipeline: two stages, advances while FIFO has room
    assign adv          = fifo_ready;
    assign pix_in_ready = adv;

    // Stage one: capture pixel
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            stage_valid_reg <= 1'b0;
            stage_reg       <= '0;
        end else if (adv) begin
            stage_valid_reg <= pix_in_valid; // [R13]
            stage_reg       <= pix_in;
        end
    end

    // Stage two: look up and convert in parallel, format-independent
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            stage2_valid_reg <= 1'b0;
            stage2_reg       <= '0;
            lut_word_reg     <= '0;
            conv_reg         <= '0;
            use_tab_reg      <= 1'b0;
        end else if (adv) begin
            stage2_valid_reg <= stage_valid_reg;
            stage2_reg       <= stage_reg;
            lut_word_reg     <= table_mem[stage_reg.value]; // [R02] [R09]
            conv_reg         <= convert(stage_reg.value, gain_reg, bright_reg); // [R01]
            use_tab_reg      <= enable_reg;
        end
    end

    // Output FIFO carries only mapped pixels and framing
    lut_fifo #(
        .width ($bits(lut_map_pkg::pix_out_t)),
        .depth (fifo_depth)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (stage2_valid_reg && adv),
        .in_ready  (fifo_ready),
        .in_data   ({use_tab_reg ? lut_word_reg : conv_reg, stage2_reg.sof, stage2_reg.eol}), // [R08]
        .out_valid (fifo_out_valid),
        .out_ready (pix_out_ready || !pix_out_valid),
        .out_data  (fifo_out)
    );

    // Registered output stage
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pix_out_valid <= 1'b0;
            pix_out       <= '0;
        end else if (pix_out_ready || !pix_out_valid) begin
            pix_out_valid <= fifo_out_valid;
            pix_out       <= fifo_out;
        end
    end

    fill_len_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        en_rise |=> (fill_reg == st_fill)[*8]) else $error("fill ended early"); // [R06]
    fill_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        en_rise |=> fill_idx_reg == 10'h000) else $error("fill not from entry 0"); // [R03]
    presence_rd_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_axi_rvalid && $rose(s_axi_rvalid) && $past(araddr_reg) == lut_map_pkg::ctrl_off
        |-> s_axi_rdata[0]) else $error("presence bit low"); // [R10]
    entry_upper_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(s_axi_rvalid) && map_hit($past(araddr_reg)) |-> s_axi_rdata[31:8] == 24'h0)
        else $error("entry upper bits set"); // [R12]
    en_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        do_write && awaddr_reg == lut_map_pkg::ctrl_off && wstrb_reg[3]
        |=> enable_reg == $past(wdata_reg[31])) else $error("enable not stored"); // [R11]
    tab_path_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        adv && stage_valid_reg && enable_reg |=> use_tab_reg) else $error("table unused"); // [R02]
    conv_path_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        adv && stage_valid_reg |=> conv_reg == convert($past(stage_reg.value), $past(gain_reg),
        $past(bright_reg))) else $error("conversion wrong"); // [R01]
    pipe_lat_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        adv && pix_in_valid ##1 adv |=> stage2_valid_reg) else $error("pixel lost"); // [R13]
endmodule : pixel_lookup_table_mapper
